// ### rtl/ability_pkg.sv
package ability_pkg;

  // ----------------------------------------
  // Management addressing
  // ----------------------------------------
  localparam logic [4:0] MGMT_DEVAD = 5'h07;
  localparam logic [15:0] ADDR_LOCAL_HIGH = 16'h0204;
  localparam logic [15:0] ADDR_PARTNER_LOW = 16'h0205;
  localparam logic [15:0] ADDR_PARTNER_MID = 16'h0206;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_LOCAL_HIGH = 16'h0000;
  localparam logic [15:0] RST_PARTNER_LOW = 16'h0000;
  localparam logic [15:0] RST_PARTNER_MID = 16'h0000;
  localparam logic [15:0] RST_PARTNER_HIGH = 16'h0000;
  localparam logic [15:0] RST_READ_DATA = 16'h0000;

  // ----------------------------------------
  // Implemented bit masks
  // ----------------------------------------
  localparam logic [15:0] LOCAL_HIGH_MASK = 16'h3000;
  localparam logic [15:0] PARTNER_LOW_MASK = 16'hFC1F;
  localparam logic [15:0] PARTNER_MID_MASK = 16'h40F0;
  localparam logic [15:0] PARTNER_HIGH_MASK = 16'h7800;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_HS_CAPABLE = 13;
  localparam int BIT_HS_REQUEST = 12;
  localparam int BIT_NEXT_PAGE = 15;
  localparam int BIT_ACK = 14;
  localparam int BIT_REMOTE_FAULT = 13;
  localparam int BIT_ROLE_FORCED = 12;
  localparam int PAUSE_MSB = 11;
  localparam int PAUSE_LSB = 10;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;
  localparam int BIT_LONG_REACH = 14;
  localparam int BIT_GIGABIT = 7;
  localparam int BIT_SHORT_REACH_FD = 6;
  localparam int BIT_FAST = 5;
  localparam int BIT_ROLE_MASTER = 4;
  localparam logic [4:0] SELECTOR_ETHERNET = 5'h01;

  // ----------------------------------------
  // Transmit level resolution states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RES_IDLE = 2'b00,
    RES_EVAL = 2'b01,
    RES_DONE = 2'b10
  } res_state_t;

endpackage

// ### rtl/autoneg_ability_regs.sv
// Operation
// RULE1: Local upper word at 0x0204, partner low/mid at 0x0205/0x0206, device 0x07.
// RULE2: Local bit 13 advertises capability for the 2.4 V p-p level.
// RULE3: Local request bit asks the partner to use the 2.4 V p-p level.
// RULE4: Either end not capable means both ends use 1.0 V p-p.
// RULE5: Both capable and either requesting means both ends use 2.4 V p-p.
// RULE6: Reading partner low word latches partner middle and high words together.
// RULE7: Partner middle word reads return the value latched at the last low read.
// RULE8: Partner low bit 15 is read-only next page request, reset zero.
// RULE9: Partner low bit 14 is read-only acknowledge of received codeword.
// RULE10: Partner low bit 13 is read-only partner remote fault.
// RULE11: Partner low bit 12 reports role preferred (0) or forced (1).
// RULE12: Partner low bits 11:10 report pause abilities, read-only.
// RULE13: Partner low bits 4:0 return received selector, 00001 for Ethernet.
// RULE14: Partner middle bit 4 reports role, 0 slave, 1 master.
// RULE15: Partner middle bits 14, 7, 6, 5 report technology abilities, read-only.
// RULE16: Reserved partner bits read zero and ignore writes.
// RULE17: Resolve transmit level only after a valid page, before data starts.
`timescale 1ns/10ps
module autoneg_ability_regs
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic MGMT_RD,
  input wire logic MGMT_WR,
  input wire logic [4:0] MGMT_DEVAD,
  input wire logic [15:0] MGMT_REGAD,
  input wire logic [15:0] MGMT_WDATA,
  output logic [15:0] MGMT_RDATA,
  output logic MGMT_ACK,
  input wire logic [47:0] PAGE_RX_WORD,
  input wire logic PAGE_RX_VALID,
  input wire logic AN_RESTART,
  output logic [15:0] LOCAL_ADV_HIGH,
  output logic TX_LEVEL_HIGH,
  output logic TX_LEVEL_READY
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hits(input logic [4:0] devad, input logic [15:0] regad,
                                input logic [15:0] target);
    hits = (devad == ability_pkg::MGMT_DEVAD) && (regad == target);
  endfunction

  function automatic logic resolve_high(input logic lcap, input logic lreq,
                                        input logic pcap, input logic preq);
    logic both_cap;
    both_cap = lcap & pcap;
    resolve_high = both_cap & (lreq | preq);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0] local_r;
  logic [15:0] partner_low_r;
  logic [15:0] partner_mid_r;
  logic [15:0] partner_high_r;
  logic [15:0] partner_low_nxt;
  logic [15:0] partner_mid_nxt;
  logic [15:0] partner_high_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic ack_r;
  logic page_seen_r;
  logic level_r;
  logic ready_r;
  logic hit_local;
  logic hit_low;
  logic hit_mid;
  logic rd_low;
  logic rd_mid;
  logic [15:0] held_mid;
  ability_pkg::res_state_t state_r;
  ability_pkg::res_state_t state_nxt;
  snap_if snap ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb
  begin
    hit_local = hits(MGMT_DEVAD, MGMT_REGAD, ability_pkg::ADDR_LOCAL_HIGH); // RULE1
    hit_low = hits(MGMT_DEVAD, MGMT_REGAD, ability_pkg::ADDR_PARTNER_LOW); // RULE1
    hit_mid = hits(MGMT_DEVAD, MGMT_REGAD, ability_pkg::ADDR_PARTNER_MID); // RULE1
    rd_low = MGMT_RD & hit_low;
    rd_mid = MGMT_RD & hit_mid;
  end

  // ----------------------------------------
  // Local advertisement upper word
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      local_r <= ability_pkg::RST_LOCAL_HIGH;
    end
    else if (MGMT_WR && hit_local)
    begin
      local_r <= MGMT_WDATA & ability_pkg::LOCAL_HIGH_MASK; // RULE2 RULE3
    end
  end

  // ----------------------------------------
  // Received partner base page
  // ----------------------------------------
  always_comb
  begin
    partner_low_nxt = PAGE_RX_WORD[15:0] & ability_pkg::PARTNER_LOW_MASK; // RULE16
    partner_mid_nxt = PAGE_RX_WORD[31:16] & ability_pkg::PARTNER_MID_MASK; // RULE16
    partner_high_nxt = PAGE_RX_WORD[47:32] & ability_pkg::PARTNER_HIGH_MASK;
  end

  // Only the engine loads these; management writes are ignored
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      partner_low_r <= ability_pkg::RST_PARTNER_LOW; // RULE8
      partner_mid_r <= ability_pkg::RST_PARTNER_MID;
      partner_high_r <= ability_pkg::RST_PARTNER_HIGH;
    end
    else if (PAGE_RX_VALID)
    begin
      partner_low_r <= partner_low_nxt; // RULE9 RULE10 RULE11 RULE12 RULE13
      partner_mid_r <= partner_mid_nxt; // RULE14 RULE15
      partner_high_r <= partner_high_nxt;
    end
  end

  // ----------------------------------------
  // Snapshot of middle and high words
  // ----------------------------------------
  always_comb
  begin
    snap.capture = rd_low; // RULE6
    snap.live = {partner_high_r, partner_mid_r};
    held_mid = snap.held[15:0];
  end

  holding_store u_hold
  (
    .clk(CLK_SYS),
    .rst(RST),
    .bus(snap)
  );

  // ----------------------------------------
  // Management read path
  // ----------------------------------------
  always_comb
  begin
    rdata_nxt = ability_pkg::RST_READ_DATA;
    if (hit_local)
    begin
      rdata_nxt = local_r;
    end
    else if (hit_low)
    begin
      rdata_nxt = partner_low_r;
    end
    else if (hit_mid)
    begin
      rdata_nxt = held_mid; // RULE7
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rdata_r <= ability_pkg::RST_READ_DATA;
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= MGMT_RD & (hit_local | hit_low | hit_mid);
      if (MGMT_RD)
      begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------
  // Transmit level resolution
  // ----------------------------------------
  // A page arriving with a restart still counts
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      page_seen_r <= 1'b0;
    end
    else if (PAGE_RX_VALID)
    begin
      page_seen_r <= 1'b1;
    end
    else if (AN_RESTART)
    begin
      page_seen_r <= 1'b0;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ability_pkg::RES_IDLE:
      begin
        if (page_seen_r)
        begin
          state_nxt = ability_pkg::RES_EVAL; // RULE17
        end
      end
      ability_pkg::RES_EVAL:
      begin
        state_nxt = ability_pkg::RES_DONE;
      end
      ability_pkg::RES_DONE:
      begin
        state_nxt = ability_pkg::RES_DONE;
      end
      default:
      begin
        state_nxt = ability_pkg::RES_IDLE;
      end
    endcase
    if (AN_RESTART)
    begin
      state_nxt = ability_pkg::RES_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state_r <= ability_pkg::RES_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Level is frozen once resolved, until the next restart
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      level_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else if (AN_RESTART)
    begin
      level_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else if (state_r == ability_pkg::RES_EVAL)
    begin
      level_r <= resolve_high(local_r[ability_pkg::BIT_HS_CAPABLE], // RULE4 RULE5
                              local_r[ability_pkg::BIT_HS_REQUEST],
                              partner_high_r[ability_pkg::BIT_HS_CAPABLE],
                              partner_high_r[ability_pkg::BIT_HS_REQUEST]);
      ready_r <= 1'b1; // RULE17
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign MGMT_RDATA = rdata_r;
  assign MGMT_ACK = ack_r;
  assign LOCAL_ADV_HIGH = local_r;
  assign TX_LEVEL_HIGH = level_r;
  assign TX_LEVEL_READY = ready_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_read_ack_map: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE1
    MGMT_RD |=> MGMT_ACK == $past(hit_local | hit_low | hit_mid))
    else $error("Read answer does not match the address map");

  a_local_write: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE2
    (MGMT_WR && hit_local) |=>
      LOCAL_ADV_HIGH == ($past(MGMT_WDATA) & ability_pkg::LOCAL_HIGH_MASK))
    else $error("Local advertisement word not written");

  a_local_readback: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE3
    (MGMT_RD && hit_local && !MGMT_WR) |=> MGMT_RDATA == LOCAL_ADV_HIGH)
    else $error("Local advertisement readback mismatch");

  a_level_low: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE4
    (state_r == ability_pkg::RES_EVAL && !AN_RESTART &&
     !(local_r[ability_pkg::BIT_HS_CAPABLE] && partner_high_r[ability_pkg::BIT_HS_CAPABLE]))
      |=> !TX_LEVEL_HIGH && TX_LEVEL_READY)
    else $error("Low level not chosen when one end is not capable");

  a_level_high: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE5
    (state_r == ability_pkg::RES_EVAL && !AN_RESTART &&
     local_r[ability_pkg::BIT_HS_CAPABLE] && partner_high_r[ability_pkg::BIT_HS_CAPABLE] &&
     (local_r[ability_pkg::BIT_HS_REQUEST] || partner_high_r[ability_pkg::BIT_HS_REQUEST]))
      |=> TX_LEVEL_HIGH && TX_LEVEL_READY)
    else $error("High level not chosen when capable and requested");

  a_mid_read_held: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE7
    rd_mid |=> MGMT_RDATA == $past(held_mid))
    else $error("Middle word read did not return latched value");

  a_low_read_live: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE13
    rd_low |=> MGMT_RDATA == $past(partner_low_r))
    else $error("Low word read returned wrong value");

  a_low_read_only: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE8
    (MGMT_WR && (hit_low || hit_mid) && !PAGE_RX_VALID) |=>
      $stable(partner_low_r) && $stable(partner_mid_r))
    else $error("Partner word changed by a management write");

  a_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE16
    MGMT_ACK |-> (partner_low_r & ~ability_pkg::PARTNER_LOW_MASK) == 16'h0000 &&
      (held_mid & ~ability_pkg::PARTNER_MID_MASK) == 16'h0000)
    else $error("Reserved partner bits not zero");

  a_page_fields: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE12 RULE14
    PAGE_RX_VALID |=> partner_mid_r[ability_pkg::BIT_ROLE_MASTER] ==
      $past(PAGE_RX_WORD[16 + ability_pkg::BIT_ROLE_MASTER]) &&
      partner_low_r[ability_pkg::PAUSE_MSB:ability_pkg::PAUSE_LSB] ==
      $past(PAGE_RX_WORD[ability_pkg::PAUSE_MSB:ability_pkg::PAUSE_LSB]))
    else $error("Received page fields not reported");

  a_ready_after_page: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE17
    !page_seen_r |-> !TX_LEVEL_READY)
    else $error("Transmit level ready before a page was received");

  a_ready_delay: assert property (@(posedge CLK_SYS) disable iff (RST) // RULE17
    ($rose(page_seen_r) && state_r == ability_pkg::RES_IDLE && !AN_RESTART) ##1 !AN_RESTART [*2]
      |-> TX_LEVEL_READY)
    else $error("Transmit level not resolved two cycles after page");

endmodule

// ### rtl/holding_store.sv
`timescale 1ns/10ps
module holding_store
(
  input wire logic clk,
  input wire logic rst,
  snap_if.store bus
);

  // ----------------------------------------
  // Latched partner middle and high words
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.held <= {ability_pkg::RST_PARTNER_HIGH, ability_pkg::RST_PARTNER_MID};
    end
    else if (bus.capture)
    begin
      bus.held <= bus.live;
    end
  end

  a_snap_capture: assert property (@(posedge clk) disable iff (rst) // RULE6
    bus.capture |=> bus.held == $past(bus.live))
    else $error("Holding words not captured on low read");

  a_snap_hold: assert property (@(posedge clk) disable iff (rst) // RULE7
    !bus.capture |=> $stable(bus.held))
    else $error("Holding words changed without a low read");

endmodule

// ### rtl/snap_if.sv
`timescale 1ns/10ps
interface snap_if;
  logic capture;
  logic [31:0] live;
  logic [31:0] held;

  modport owner
  (
    output capture,
    output live,
    input held
  );

  modport store
  (
    input capture,
    input live,
    output held
  );
endinterface

// ### sim/page_source.sv
`timescale 1ns/10ps
module page_source
(
  input wire logic clk,
  input wire logic send,
  input wire logic [47:0] word,
  output logic [47:0] page_word,
  output logic page_valid
);
  // ----------------------------------------
  // Received base page delivery
  // ----------------------------------------
  logic [47:0] last_r = 48'h000000000000;
  assign page_valid = send;
  // Outside a valid cycle the word is garbage that flips each cycle
  assign page_word = send ? word : ~last_r;
  always_ff @(posedge clk)
  begin
    if (send)
      last_r <= word;
    else
      last_r <= ~last_r;
  end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [4:0] devad = 5'h00;
  logic [15:0] regad = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic send = 1'b0;
  logic [47:0] word = 48'h000000000000;
  logic restart = 1'b0;
  logic [47:0] page_word;
  logic page_valid;
  logic [15:0] rdata;
  logic ack;
  logic [15:0] adv_high;
  logic lvl_high;
  logic lvl_ready;
  int fail_count = 0;
  int compares = 0;
  int waits = 0;
  logic [15:0] rv;
  logic av;
  logic [15:0] loc;
  logic [47:0] pg;
  logic [47:0] pg2;

  always #5 clk = ~clk;

  page_source page_source_i
  (
    .clk(clk),
    .send(send),
    .word(word),
    .page_word(page_word),
    .page_valid(page_valid)
  );

  autoneg_ability_regs autoneg_ability_regs_i
  (
    .CLK_SYS(clk),
    .RST(rst),
    .MGMT_RD(rd),
    .MGMT_WR(wr),
    .MGMT_DEVAD(devad),
    .MGMT_REGAD(regad),
    .MGMT_WDATA(wdata),
    .MGMT_RDATA(rdata),
    .MGMT_ACK(ack),
    .PAGE_RX_WORD(page_word),
    .PAGE_RX_VALID(page_valid),
    .AN_RESTART(restart),
    .LOCAL_ADV_HIGH(adv_high),
    .TX_LEVEL_HIGH(lvl_high),
    .TX_LEVEL_READY(lvl_ready)
  );

  // ----------------------------------------
  // Compare, bus and page tasks
  // ----------------------------------------
  task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic mgmt_write(input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
    devad = d;
    regad = a;
    wdata = v;
    wr = 1'b1;
    step();
    wr = 1'b0;
    step();
  endtask

  task automatic mgmt_read(input logic [4:0] d, input logic [15:0] a, output logic [15:0] v,
                           output logic k);
    devad = d;
    regad = a;
    rd = 1'b1;
    step();
    rd = 1'b0;
    v = rdata;
    k = ack;
    step();
    chk1("ack_pulse", 1'b0, ack);
  endtask

  task automatic send_page(input logic [47:0] p);
    word = p;
    send = 1'b1;
    step();
    send = 1'b0;
    step();
  endtask

  function automatic logic exp_level(input logic lc, input logic lr, input logic pc,
                                     input logic pr);
    return lc & pc & (lr | pr);
  endfunction

  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hE77ED9E8));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    mgmt_read(5'h07, 16'h0204, rv, av);
    chk16("local_high", 16'h0000, rv);
    chk1("ack", 1'b1, av);
    mgmt_read(5'h07, 16'h0205, rv, av);
    chk16("partner_low", 16'h0000, rv);
    chk1("ready", 1'b0, lvl_ready);
    $display("test reset done");
    loc = 16'($urandom);
    mgmt_write(5'h07, 16'h0204, loc);
    mgmt_write(5'h06, 16'h0204, ~loc);
    mgmt_read(5'h07, 16'h0204, rv, av);
    chk16("local_high", loc & 16'h3000, rv);
    chk16("adv_high", loc & 16'h3000, adv_high);
    pg = 48'({$urandom, $urandom});
    pg[4:0] = ability_pkg::SELECTOR_ETHERNET;
    send_page(pg);
    mgmt_write(5'h07, 16'h0205, 16'hFFFF);
    mgmt_write(5'h07, 16'h0206, 16'hFFFF);
    mgmt_read(5'h07, 16'h0206, rv, av);
    chk16("partner_mid", 16'h0000, rv);
    mgmt_read(5'h07, 16'h0205, rv, av);
    chk16("partner_low", pg[15:0] & 16'hFC1F, rv);
    pg2 = 48'({$urandom, $urandom});
    send_page(pg2);
    mgmt_read(5'h07, 16'h0206, rv, av);
    chk16("partner_mid", pg[31:16] & 16'h40F0, rv);
    mgmt_read(5'h07, 16'h0205, rv, av);
    chk16("partner_low", pg2[15:0] & 16'hFC1F, rv);
    mgmt_read(5'h07, 16'h0206, rv, av);
    chk16("partner_mid", pg2[31:16] & 16'h40F0, rv);
    mgmt_read(5'h07, 16'h0207, rv, av);
    chk16("unmapped", 16'h0000, rv);
    chk1("ack", 1'b0, av);
    mgmt_read(5'h06, 16'h0205, rv, av);
    chk1("ack", 1'b0, av);
    $display("test registers done");
    for (int i = 0; i < 16; i++)
    begin
      restart = 1'b1;
      step();
      restart = 1'b0;
      loc = 16'($urandom);
      loc[13] = i[3];
      loc[12] = i[2];
      mgmt_write(5'h07, 16'h0204, loc);
      chk1("ready", 1'b0, lvl_ready);
      pg = 48'({$urandom, $urandom});
      pg[45] = i[1];
      pg[44] = i[0];
      send_page(pg);
      waits = 0;
      repeat (6)
      begin
        if (lvl_ready === 1'b1)
          break;
        step();
        waits++;
      end
      chk1("ready", 1'b1, lvl_ready);
      chk16("ready_delay", 16'h0001, 16'(waits));
      chk1("level", exp_level(i[3], i[2], i[1], i[0]), lvl_high);
      send_page(~pg);
      chk1("level", exp_level(i[3], i[2], i[1], i[0]), lvl_high);
    end
    $display("test resolution done");
    // Page and restart in one cycle: the page still counts
    pg = 48'({$urandom, $urandom});
    pg[45] = 1'b1;
    word = pg;
    send = 1'b1;
    restart = 1'b1;
    step();
    send = 1'b0;
    restart = 1'b0;
    step();
    chk1("ready", 1'b0, lvl_ready);
    step();
    chk1("ready", 1'b1, lvl_ready);
    chk1("level", exp_level(loc[13], loc[12], pg[45], pg[44]), lvl_high);
    $display("test restart with page done");
    // Reset in mid-run
    rst = 1'b1;
    step();
    step();
    rst = 1'b0;
    chk16("adv_high", 16'h0000, adv_high);
    chk1("ready", 1'b0, lvl_ready);
    chk1("level", 1'b0, lvl_high);
    mgmt_read(5'h07, 16'h0206, rv, av);
    chk16("partner_mid", 16'h0000, rv);
    mgmt_read(5'h07, 16'h0205, rv, av);
    chk16("partner_low", 16'h0000, rv);
    $display("test reset again done");
    wrap_up();
  end
endmodule
